// ===== hw/eip_defs.svh
// Timing and field constants for the event interrupt pulser.
// Assumes a 125 MHz system clock.
`ifndef EIP_DEFS_SVH
`define EIP_DEFS_SVH

`define EIP_CLK_MHZ 125
// Nominal pulse width and minimum gap, microseconds
`define EIP_PULSE_US 100
`define EIP_GAP_US 100
// Pending repeat period, milliseconds
`define EIP_REPEAT_MS 5
// Development mode select filter, microseconds
`define EIP_DEVSEL_US 64
`define EIP_PULSE_CYC (`EIP_PULSE_US * `EIP_CLK_MHZ)
`define EIP_GAP_CYC (`EIP_GAP_US * `EIP_CLK_MHZ)
`define EIP_REPEAT_CYC (`EIP_REPEAT_MS * 1000 * `EIP_CLK_MHZ)
`define EIP_DEVSEL_CYC (`EIP_DEVSEL_US * `EIP_CLK_MHZ)
`define EIP_CNT_W 24

// Group mask bit positions
`define EIP_GRP_SUPPLY 0
`define EIP_GRP_THERMAL 1
`define EIP_GRP_BUS 2
`define EIP_GRP_HIGHSIDE 3
`define EIP_GRP_BRIDGE 4
`define EIP_GRP_SERIAL 5
`define EIP_GRP_W 6
`define EIP_WAKE_W 8
`define EIP_STAT_W 8

`endif

// ===== hw/eip_pkg.sv
// Types for the event interrupt pulser.
// Used with eip_defs.svh for numeric constants.
package eip_pkg;
  typedef enum logic [2:0] {
    EIP_MODE_INIT,
    EIP_MODE_NORMAL,
    EIP_MODE_STOP,
    EIP_MODE_SLEEP,
    EIP_MODE_RESTART,
    EIP_MODE_FAILSAFE
  } eip_mode_t;

  typedef enum logic [1:0] {
    EIP_ST_IDLE,
    EIP_ST_LOW,
    EIP_ST_GAP
  } eip_state_t;
endpackage : eip_pkg

// ===== hw/eip_sync_filter.sv
// Two-flop synchroniser followed by a stable-level filter.
// Assumes an asynchronous pin input and the system clock.
`timescale 1ns/1ns
`include "eip_defs.svh"

module eip_sync_filter #(
  parameter int FILT_CYC = 8
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic pin_in,
  output logic level_out
);
  logic meta_reg;
  logic sync_reg;
  logic last_reg;
  logic level_reg;
  logic [`EIP_CNT_W-1:0] cnt_reg;
  logic [`EIP_CNT_W-1:0] cnt_next;
  logic changed;
  logic settled;

  assign changed = sync_reg != last_reg;
  assign settled = cnt_reg == `EIP_CNT_W'(FILT_CYC - 1);
  assign cnt_next = changed ? '0 : (settled ? cnt_reg : cnt_reg + `EIP_CNT_W'(1));
  assign level_out = level_reg;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
      last_reg <= 1'b1;
      level_reg <= 1'b1;
      cnt_reg <= '0;
    end else begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
      cnt_reg <= cnt_next;
      if (settled && !changed) begin
        level_reg <= last_reg;
      end
    end
  end
endmodule : eip_sync_filter

// ===== hw/eip_pulser.sv
// Interrupt pulse generator: group and wake events to an active-low pulse.
// Assumes status inputs are on clk_in; the interrupt pin readback is async.
// Operation
// [R1] Pulse low for nominal width in Normal/Stop
// [R2] Hold high for minimum gap between pulses
// [R3] Interrupt never changes the operating mode
// [R4] Group mask enables each status group
// [R5] Group flag is OR of its bits
// [R6] Wake bit interrupts only if source enabled; Stop entry pulses on any set wake_status_in bit, enabled or not
// [R7] Wake sources include brake when feature enabled
// [R8] Group and wake interrupts both active
// [R9] Rail, shutdown and power-on flags never interrupt
// [R10] No pulses in Restart, Fail-Safe, Sleep
// [R11] Stop entry pulses on uncleared wake/brake bits
// [R12] Status snapshot updates at pulse falling edge
// [R13] Events stay latched until software clears
// [R14] Host may re-read status after clearing
// [R15] Pending events repeat at the repeat period
// [R16] Only serial error flags cause repeats
// [R17] Repeat enable bit disables periodic pulses
// [R18] Events during low pulse merge into one
// [R19] Init samples filtered pin for dev mode
// [R20] Counters time width, gap and period
`timescale 1ns/1ns
`include "eip_defs.svh"

module eip_pulser #(
  parameter int REPEAT_CYC = `EIP_REPEAT_CYC
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire eip_pkg::eip_mode_t mode_in,
  input wire logic [`EIP_GRP_W-1:0] group_mask_in,
  input wire logic repeat_pulse_enable_in,
  input wire logic [`EIP_STAT_W-1:0] supply_status_in,
  input wire logic main_rail_undervolt_in,
  input wire logic main_rail_short_in,
  input wire logic main_rail_overvolt_in,
  input wire logic power_on_flag_in,
  input wire logic [`EIP_STAT_W-1:0] thermal_status_in,
  input wire logic thermal_shutdown_level2_in,
  input wire logic [`EIP_STAT_W-1:0] bus_status_in,
  input wire logic [`EIP_STAT_W-1:0] highside_fault_status_in,
  input wire logic [`EIP_STAT_W-1:0] drain_source_overvolt_status_in,
  input wire logic serial_frame_error_in,
  input wire logic checksum_error_in,
  input wire logic [`EIP_WAKE_W-1:0] wake_status_in,
  input wire logic [`EIP_WAKE_W-1:0] wake_source_enable_in,
  input wire logic [`EIP_WAKE_W-1:0] lowside_brake_flag_in,
  input wire logic brake_feature_enable_in,
  input wire logic int_pin_level_in,
  output logic int_n_out,
  output logic int_n_oe_out,
  output logic status_update_out,
  output logic [`EIP_GRP_W-1:0] group_snapshot_out,
  output logic [`EIP_WAKE_W-1:0] wake_snapshot_out,
  output logic software_dev_mode_out
);
  localparam int PULSE_CYC = `EIP_PULSE_CYC;
  localparam int GAP_CYC = `EIP_GAP_CYC;

  eip_pkg::eip_state_t state_reg;
  eip_pkg::eip_state_t state_next;
  logic [`EIP_CNT_W-1:0] cnt_reg;
  logic [`EIP_CNT_W-1:0] cnt_next;
  logic [`EIP_CNT_W-1:0] rep_cnt_reg;
  logic [`EIP_GRP_W-1:0] grp_prev_reg;
  logic [`EIP_WAKE_W-1:0] wake_prev_reg;
  logic pend_reg;
  logic stop_prev_reg;
  logic [`EIP_GRP_W-1:0] grp_snap_reg;
  logic [`EIP_WAKE_W-1:0] wake_snap_reg;
  logic update_reg;
  logic devmode_reg;
  logic init_prev_reg;
  logic pin_filt;

  logic [`EIP_GRP_W-1:0] grp_flags;
  logic [`EIP_GRP_W-1:0] grp_active;
  logic [`EIP_WAKE_W-1:0] wake_active;
  logic [`EIP_WAKE_W-1:0] brake_active;
  logic new_event;
  logic stop_entry;
  logic serial_pending;
  logic repeat_due;
  logic pulse_allowed;
  logic trigger;
  logic cnt_done;
  logic fall;

  // [R5] Group flags as OR of members
  assign grp_flags[`EIP_GRP_SUPPLY] = |supply_status_in;
  assign grp_flags[`EIP_GRP_THERMAL] = |thermal_status_in;
  assign grp_flags[`EIP_GRP_BUS] = |bus_status_in;
  assign grp_flags[`EIP_GRP_HIGHSIDE] = |highside_fault_status_in;
  assign grp_flags[`EIP_GRP_BRIDGE] = |drain_source_overvolt_status_in;
  assign grp_flags[`EIP_GRP_SERIAL] = serial_frame_error_in | checksum_error_in;
  // [R9] Rail, shutdown and power-on flags arrive on their own ports and are not ORed
  // [R4] Group mask gating
  assign grp_active = grp_flags & group_mask_in;
  // [R6] Wake bits gated by source enable
  assign wake_active = wake_status_in & wake_source_enable_in;
  // [R7] Brake events count when a brake feature is on
  assign brake_active = brake_feature_enable_in ? lowside_brake_flag_in : '0;

  // [R8] Either kind raises a new event on a rising flag
  assign new_event = |(grp_active & ~grp_prev_reg) | |((wake_active | brake_active) & ~wake_prev_reg);
  // [R11] Stop entry with uncleared wake or brake bits
  assign stop_entry = (mode_in == eip_pkg::EIP_MODE_STOP) && !stop_prev_reg
    && (|wake_status_in || |lowside_brake_flag_in);
  // [R16] Only serial error flags keep repeating
  assign serial_pending = serial_frame_error_in | checksum_error_in;
  // [R15] [R17] Repeat after the period if enabled
  assign repeat_due = repeat_pulse_enable_in && pend_reg && serial_pending
    && rep_cnt_reg == `EIP_CNT_W'(REPEAT_CYC - 1);
  // [R10] [R3] Only Normal and Stop may pulse; the mode is an input only
  assign pulse_allowed = mode_in == eip_pkg::EIP_MODE_NORMAL || mode_in == eip_pkg::EIP_MODE_STOP;
  assign trigger = pulse_allowed && (new_event || stop_entry || repeat_due);
  assign fall = state_reg == eip_pkg::EIP_ST_IDLE && trigger;

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg + `EIP_CNT_W'(1);
    cnt_done = 1'b0;
    case (state_reg)
      eip_pkg::EIP_ST_IDLE: begin
        cnt_next = '0;
        if (trigger) begin
          state_next = eip_pkg::EIP_ST_LOW;
        end
      end
      eip_pkg::EIP_ST_LOW: begin
        // [R1] [R20] Pulse width count
        cnt_done = cnt_reg == `EIP_CNT_W'(PULSE_CYC - 1);
        if (cnt_done) begin
          state_next = eip_pkg::EIP_ST_GAP;
          cnt_next = '0;
        end
      end
      eip_pkg::EIP_ST_GAP: begin
        // [R2] [R20] Minimum gap count
        cnt_done = cnt_reg == `EIP_CNT_W'(GAP_CYC - 1);
        if (cnt_done) begin
          state_next = eip_pkg::EIP_ST_IDLE;
          cnt_next = '0;
        end
      end
      default: begin
        state_next = eip_pkg::EIP_ST_IDLE;
        cnt_next = '0;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_reg <= eip_pkg::EIP_ST_IDLE;
      cnt_reg <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
    end
  end

  // Edge memory: events that rise during a pulse or gap are held pending
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      grp_prev_reg <= '0;
      wake_prev_reg <= '0;
      stop_prev_reg <= 1'b0;
    end else begin
      stop_prev_reg <= mode_in == eip_pkg::EIP_MODE_STOP;
      // [R18] Flags latch as seen when a pulse starts or pulsing is not allowed, so bursts merge
      if (fall || !pulse_allowed) begin
        grp_prev_reg <= grp_active;
        wake_prev_reg <= wake_active | brake_active;
      end else begin
        grp_prev_reg <= grp_prev_reg & grp_active;
        wake_prev_reg <= wake_prev_reg & (wake_active | brake_active);
      end
    end
  end

  // [R15] Repeat period counter, restarted by each pulse
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rep_cnt_reg <= '0;
      pend_reg <= 1'b0;
    end else begin
      if (fall) begin
        rep_cnt_reg <= '0;
        pend_reg <= 1'b1;
      end else if (!serial_pending || !repeat_pulse_enable_in) begin
        rep_cnt_reg <= '0;
        pend_reg <= 1'b0;
      end else if (rep_cnt_reg != `EIP_CNT_W'(REPEAT_CYC - 1)) begin
        rep_cnt_reg <= rep_cnt_reg + `EIP_CNT_W'(1);
      end
    end
  end

  // [R12] [R13] Snapshot latched flags at each falling edge
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      grp_snap_reg <= '0;
      wake_snap_reg <= '0;
      update_reg <= 1'b0;
    end else begin
      update_reg <= fall;
      if (fall) begin
        grp_snap_reg <= grp_flags;
        wake_snap_reg <= wake_status_in | lowside_brake_flag_in;
      end
    end
  end

  // [R19] Filtered pin level for development mode select
  eip_sync_filter #(
    .FILT_CYC(`EIP_DEVSEL_CYC)
  ) u_devsel_filter (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .pin_in(int_pin_level_in),
    .level_out(pin_filt)
  );

  // [R19] Decision follows the filtered pin on every cycle of Init mode, then holds
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      devmode_reg <= 1'b0;
      init_prev_reg <= 1'b0;
    end else begin
      init_prev_reg <= mode_in == eip_pkg::EIP_MODE_INIT;
      if (mode_in == eip_pkg::EIP_MODE_INIT) begin
        devmode_reg <= !pin_filt;
      end
    end
  end

  // [R1] Drive low only during the pulse; pin left released in Init for sampling
  assign int_n_out = state_reg != eip_pkg::EIP_ST_LOW;
  assign int_n_oe_out = mode_in != eip_pkg::EIP_MODE_INIT;
  assign status_update_out = update_reg;
  assign group_snapshot_out = grp_snap_reg;
  assign wake_snapshot_out = wake_snap_reg;
  assign software_dev_mode_out = devmode_reg;
endmodule : eip_pulser

// ===== dv/eip_pulser_assertions.sv
// Port-level checker for the interrupt pulser.
// Assumes binding into eip_pulser, one clock domain.
`timescale 1ns/1ns
`include "eip_defs.svh"
module eip_pulser_assertions #(
  parameter int REPEAT_CYC = 30000
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire eip_pkg::eip_mode_t mode_in,
  input wire logic int_n_out,
  input wire logic int_n_oe_out,
  input wire logic status_update_out,
  input wire logic [`EIP_GRP_W-1:0] group_snapshot_out,
  input wire logic [`EIP_WAKE_W-1:0] wake_snapshot_out,
  input wire logic software_dev_mode_out
);
  logic [15:0] low_cnt;
  logic [15:0] high_cnt;
  // Low and saturating high run counters
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      low_cnt <= 16'h0000;
      high_cnt <= 16'h30D4;
    end else begin
      low_cnt <= int_n_out ? 16'h0000 : low_cnt + 16'h0001;
      high_cnt <= !int_n_out ? 16'h0000 : (high_cnt == 16'h30D4 ? high_cnt : high_cnt + 16'h0001);
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  property p_width; $rose(int_n_out) |-> low_cnt == 16'h30D4; endproperty
  a_width: assert property (p_width) else $error("pulse width wrong");
  property p_gap; $fell(int_n_out) |-> high_cnt == 16'h30D4; endproperty
  a_gap: assert property (p_gap) else $error("gap before pulse too short");
  property p_mode;
    $fell(int_n_out) |-> $past(mode_in) inside {eip_pkg::EIP_MODE_NORMAL, eip_pkg::EIP_MODE_STOP};
  endproperty
  a_mode: assert property (p_mode) else $error("pulse outside Normal or Stop");
  property p_update; status_update_out == $fell(int_n_out); endproperty
  a_update: assert property (p_update) else $error("update not at falling edge");
  property p_snap; !status_update_out |-> $stable(group_snapshot_out) && $stable(wake_snapshot_out); endproperty
  a_snap: assert property (p_snap) else $error("snapshot moved without update");
  property p_drive; !int_n_out |-> int_n_oe_out; endproperty
  a_drive: assert property (p_drive) else $error("low pulse not driven");
  property p_oe_init;
    mode_in == eip_pkg::EIP_MODE_INIT && $past(mode_in) == eip_pkg::EIP_MODE_INIT |-> !int_n_oe_out;
  endproperty
  a_oe_init: assert property (p_oe_init) else $error("pin driven in Init");
  property p_dev_hold;
    mode_in != eip_pkg::EIP_MODE_INIT && $past(mode_in) != eip_pkg::EIP_MODE_INIT |-> $stable(software_dev_mode_out);
  endproperty
  a_dev_hold: assert property (p_dev_hold) else $error("dev mode moved outside Init");
  c_pulse: cover property ($fell(int_n_out));
  c_stop: cover property ($fell(int_n_out) && mode_in == eip_pkg::EIP_MODE_STOP);
  c_dev: cover property ($rose(software_dev_mode_out));
endmodule : eip_pulser_assertions

bind eip_pulser eip_pulser_assertions #(.REPEAT_CYC(REPEAT_CYC)) eip_pulser_assertions_i (
  .clk_in(clk_in), .reset_n_in(reset_n_in), .mode_in(mode_in), .int_n_out(int_n_out),
  .int_n_oe_out(int_n_oe_out), .status_update_out(status_update_out), .group_snapshot_out(group_snapshot_out),
  .wake_snapshot_out(wake_snapshot_out), .software_dev_mode_out(software_dev_mode_out));

// ===== dv/eip_host_model.sv
// Host side of the interrupt line: counts pulses, measures width and period.
// Assumes the line is sampled on the system clock.
`timescale 1ns/1ns
module eip_host_model (
  input wire logic clk_in,
  input wire logic int_n_in,
  input wire logic en_in,
  output logic [7:0] pulse_cnt_out,
  output logic [31:0] low_len_out,
  output logic [31:0] period_out
);
  logic [31:0] cyc = 32'h0;
  logic [31:0] last_fall = 32'h0;
  logic [31:0] low_run = 32'h0;
  logic prev = 1'b1;
  initial begin
    pulse_cnt_out = 8'h00;
    low_len_out = 32'h0;
    period_out = 32'h0;
  end
  always @(posedge clk_in) begin
    cyc <= cyc + 32'h1;
    // Line ignored while the device is not driving it
    prev <= en_in ? int_n_in : 1'b1;
    low_run <= int_n_in ? 32'h0 : low_run + 32'h1;
    if (en_in && prev && !int_n_in) begin
      pulse_cnt_out <= pulse_cnt_out + 8'h01;
      period_out <= cyc - last_fall;
      last_fall <= cyc;
    end
    if (en_in && !prev && int_n_in) begin
      low_len_out <= low_run;
    end
  end
endmodule : eip_host_model

// ===== dv/eip_pulser_test.sv
// Self-checking bench for the interrupt pulser.
// Assumes a shortened repeat period and the host model on the pin.
`timescale 1ns/1ns
module eip_pulser_test;
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  eip_pkg::eip_mode_t mode = eip_pkg::EIP_MODE_INIT;
  logic [5:0] mask = 6'h00;
  logic rep_en = 1'b0, rail_uv = 1'b0, rail_sc = 1'b0, rail_ov = 1'b0, por = 1'b0, thermal_shutdown_level2 = 1'b0;
  logic frame_err = 1'b0, crc_err = 1'b0, brake_en = 1'b0, pin_drv = 1'b0;
  logic [7:0] supply = 8'h00, thermal = 8'h00, bus = 8'h00, hs_fault = 8'h00, drain_source_overvolt_status = 8'h00;
  logic [7:0] wake = 8'h00, wake_en = 8'h00, brake = 8'h00;
  logic int_n_out, int_n_oe_out, status_update_out, software_dev_mode_out;
  logic [5:0] group_snapshot_out;
  logic [7:0] wake_snapshot_out, pulse_cnt;
  logic [31:0] low_len, period;
  int error_cnt = 0;
  int checks = 0;
  int cyc = 0;
  wire int_pin = int_n_oe_out ? int_n_out : pin_drv;
  always #4 clk_in = ~clk_in;
  eip_pulser #(.REPEAT_CYC(30000)) eip_pulser_i (.clk_in(clk_in), .reset_n_in(reset_n_in), .mode_in(mode),
    .group_mask_in(mask), .repeat_pulse_enable_in(rep_en), .supply_status_in(supply),
    .main_rail_undervolt_in(rail_uv), .main_rail_short_in(rail_sc), .main_rail_overvolt_in(rail_ov),
    .power_on_flag_in(por), .thermal_status_in(thermal), .thermal_shutdown_level2_in(thermal_shutdown_level2),
    .bus_status_in(bus), .highside_fault_status_in(hs_fault), .drain_source_overvolt_status_in(drain_source_overvolt_status),
    .serial_frame_error_in(frame_err), .checksum_error_in(crc_err), .wake_status_in(wake),
    .wake_source_enable_in(wake_en), .lowside_brake_flag_in(brake), .brake_feature_enable_in(brake_en),
    .int_pin_level_in(int_pin), .int_n_out(int_n_out), .int_n_oe_out(int_n_oe_out),
    .status_update_out(status_update_out), .group_snapshot_out(group_snapshot_out),
    .wake_snapshot_out(wake_snapshot_out), .software_dev_mode_out(software_dev_mode_out));
  eip_host_model eip_host_model_i (.clk_in(clk_in), .int_n_in(int_pin), .en_in(int_n_oe_out), .pulse_cnt_out(pulse_cnt),
    .low_len_out(low_len), .period_out(period));
  task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %0h seen %0h", name, exp, got);
    end
  endtask : cmp
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask : tick
  task automatic wrap_up();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : wrap_up
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      error_cnt++;
      $display("mismatch timeout expected done seen hang");
      wrap_up();
    end
  end
  initial begin
    tick(8);
    reset_n_in <= 1'b1;
    tick(8100);
    cmp("dev_mode", 32'h1, 32'(software_dev_mode_out));
    cmp("oe_init", 32'h0, 32'(int_n_oe_out));
    $display("test init done");
    mode <= eip_pkg::EIP_MODE_NORMAL;
    mask <= 6'h3D;
    rep_en <= 1'b1;
    {rail_uv, rail_sc, rail_ov, por, thermal_shutdown_level2, thermal, wake} <= {5'h1F, 8'h01, 8'h02};
    tick(200);
    cmp("quiet_pulses", 32'h0, 32'(pulse_cnt));
    $display("test quiet done");
    {thermal, wake, supply, bus, frame_err} <= {8'h00, 8'h00, 8'h01, 8'h01, 1'b1};
    tick(12600);
    cmp("merged_pulses", 32'h1, 32'(pulse_cnt));
    cmp("low_len", 32'h30D4, low_len);
    cmp("group_snapshot", 32'h25, 32'(group_snapshot_out));
    {supply, bus} <= 16'h0000;
    tick(17500);
    cmp("repeat_pulses", 32'h2, 32'(pulse_cnt));
    cmp("repeat_period", 32'h7530, period);
    rep_en <= 1'b0;
    tick(31000);
    cmp("no_repeat", 32'h2, 32'(pulse_cnt));
    $display("test repeat done");
    {frame_err, wake, wake_en} <= {1'b0, 8'h01, 8'h01};
    mode <= eip_pkg::EIP_MODE_SLEEP;
    tick(200);
    cmp("sleep_pulses", 32'h2, 32'(pulse_cnt));
    mode <= eip_pkg::EIP_MODE_STOP;
    tick(12600);
    cmp("stop_pulses", 32'h3, 32'(pulse_cnt));
    cmp("wake_snapshot", 32'h01, 32'(wake_snapshot_out));
    wake <= 8'h00;
    tick(20);
    cmp("pulses_after_clear", 32'h3, 32'(pulse_cnt));
    cmp("snapshot_after_clear", 32'h01, 32'(wake_snapshot_out));
    $display("test stop done");
    wrap_up();
  end
endmodule : eip_pulser_test
